/* bench/aopd_bank_properties.sv */
// assertions on the ports of the record bank
// assumes a bind to the bank and a single clock domain
`timescale 1ns/1ps
module aopd_bank_checker (
    // clock and reset
    input wire logic SYS_CLK_I,
    input wire logic SYS_RST_I,
    // access port
    input wire logic ACC_REQ_I,
    input wire logic ACC_ACK_O,
    input wire logic ACC_ERR_O,
    input wire logic [7:0] ACC_RDATA_O,
    // channels
    input wire logic [3:0] CH_SHORT_I,
    input wire logic [63:0] CH_VALUE_I,
    input wire logic [47:0] CH_DAC_O,
    input wire logic [3:0] CH_ACTIVE_O,
    input wire logic [3:0] CH_ERR_LED_O
);
    default clocking @(posedge SYS_CLK_I); endclocking
    default disable iff (SYS_RST_I);
    logic [47:0] off_mask;
    assign off_mask = {{12{!CH_ACTIVE_O[3]}}, {12{!CH_ACTIVE_O[2]}},
        {12{!CH_ACTIVE_O[1]}}, {12{!CH_ACTIVE_O[0]}}};
    property p_answer;
        ACC_REQ_I && !ACC_ACK_O |=> ACC_ACK_O ##1 !ACC_ACK_O;
    endproperty
    a_answer: assert property (p_answer) else $error("no single answer");
    property p_quiet;
        !(ACC_REQ_I && !ACC_ACK_O) |=> !ACC_ACK_O;
    endproperty
    a_quiet: assert property (p_quiet) else $error("answer without request");
    property p_hold;
        !ACC_ACK_O |-> $stable(ACC_RDATA_O) && $stable(ACC_ERR_O);
    endproperty
    a_hold: assert property (p_hold) else $error("answer changed while idle");
    property p_err_zero;
        ACC_ACK_O && ACC_ERR_O |-> ACC_RDATA_O == 8'h00;
    endproperty
    a_err_zero: assert property (p_err_zero) else $error("refusal with data");
    property p_off;
        1'b1 |=> (CH_DAC_O & $past(off_mask)) == 48'h0;
    endproperty
    a_off: assert property (p_off) else $error("inactive channel drives");
    property p_neg;
        CH_VALUE_I[15] |=> CH_DAC_O[11:0] == 12'h000;
    endproperty
    a_neg: assert property (p_neg) else $error("negative value not clamped");
    property p_range;
        CH_DAC_O[11:0] <= 12'ha00 && CH_DAC_O[47:36] <= 12'ha00;
    endproperty
    a_range: assert property (p_range) else $error("code beyond overrange");
    property p_led;
        (CH_SHORT_I == 4'h0 && $stable(CH_ACTIVE_O)) [*5] |-> (CH_ERR_LED_O & CH_ACTIVE_O) == 4'h0;
    endproperty
    a_led: assert property (p_led) else $error("indicator without fault");
    c_refused: cover property (ACC_ACK_O && ACC_ERR_O);
    c_read: cover property (ACC_ACK_O && ACC_RDATA_O != 8'h00);
    c_led: cover property (CH_ERR_LED_O != 4'h0);
endmodule

bind aopd_bank aopd_bank_checker i_aopd_bank_checker (.SYS_CLK_I, .SYS_RST_I, .ACC_REQ_I,
    .ACC_ACK_O, .ACC_ERR_O, .ACC_RDATA_O, .CH_SHORT_I, .CH_VALUE_I, .CH_DAC_O, .CH_ACTIVE_O,
    .CH_ERR_LED_O);

/* bench/aopd_host.sv */
// host model issuing single byte record accesses
// assumes the bench calls xfer; requests change only at falling edges
`timescale 1ns/1ps
module aopd_host (
    // clock
    input wire logic clk_i,
    // request
    output logic req_o,
    output logic wr_o,
    output aopd_pkg::aopd_path_e path_o,
    output logic [15:0] sel_o,
    output logic [7:0] sub_o,
    output logic [4:0] byte_o,
    output logic [7:0] wdata_o,
    // answer
    input wire logic ack_i,
    input wire logic err_i,
    input wire logic [7:0] rdata_i
);
    import aopd_pkg::*;
    initial begin
        {req_o, wr_o, sel_o, sub_o, byte_o, wdata_o} = '0;
        path_o = AOPD_PATH_RECORD;
    end
    // ok stays low when no answer comes within the bound
    task automatic xfer(input logic w, input aopd_path_e p, input logic [15:0] s,
            input logic [7:0] sb, input logic [4:0] b, input logic [7:0] wd,
            output logic [7:0] rd, output logic er, output logic ok);
        int n;
        @(negedge clk_i);
        {req_o, wr_o, sel_o, sub_o, byte_o, wdata_o} = {1'b1, w, s, sb, b, wd};
        path_o = p;
        n = 0;
        // look at the answer mid-cycle, away from the edge that launches it
        do begin
            @(negedge clk_i);
            n++;
        end while (ack_i !== 1'b1 && n < 8);
        {rd, er, ok} = {rdata_i, err_i, ack_i === 1'b1};
        // the request stands through the edge at which the answer is high
        @(posedge clk_i);
        @(negedge clk_i);
        req_o = 1'b0;
        // released select, subindex, byte and write data never keep their last value; wr_o and path_o do
        {sel_o, sub_o, byte_o, wdata_o} = ~{sel_o, sub_o, byte_o, wdata_o};
    endtask
endmodule

/* bench/tb_analog_output_param_diag.sv */
// self-checking bench of the analog output record bank
// assumes the host model and the bound checker
`timescale 1ns/1ps
module tb_analog_output_param_diag;
    import aopd_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic req, wr, ack, err;
    aopd_path_e path;
    logic [15:0] sel;
    logic [7:0] sub, wdata, rdata;
    logic [4:0] bnum;
    logic [3:0] shorts = 4'h0;
    logic [3:0] sen = 4'h0;
    logic [5:0] pins = 6'h0;
    logic [63:0] val = 64'h0;
    logic [47:0] dac;
    logic [3:0] act, led;
    logic [7:0] code [4] = '{8'h10, 8'h10, 8'h10, 8'h10};
    logic [7:0] tbl [4] = '{8'h10, 8'h20, 8'hff, 8'h5a};
    logic [127:0] dimg;
    logic [31:0] stamp;
    logic [31:0] seed = 32'd63698;
    int n_fail = 0;
    int compares = 0;
    always #20 clk = ~clk;
    aopd_bank i_aopd_bank (.SYS_CLK_I(clk), .SYS_RST_I(rst), .ACC_REQ_I(req), .ACC_WR_I(wr),
        .ACC_PATH_I(path), .ACC_SEL_I(sel), .ACC_SUB_I(sub), .ACC_BYTE_I(bnum),
        .ACC_WDATA_I(wdata), .ACC_ACK_O(ack), .ACC_ERR_O(err), .ACC_RDATA_O(rdata),
        .CH_SHORT_I(shorts), .MOD_FAIL_I(pins[0]), .INT_ERR_I(pins[1]), .EXT_ERR_I(pins[2]),
        .AUX_MISSING_I(pins[3]), .DIAG_OVF_I(pins[4]), .COMM_ERR_I(pins[5]),
        .CH_VALUE_I(val), .CH_DAC_O(dac), .CH_ACTIVE_O(act), .CH_ERR_LED_O(led));
    aopd_host host (.clk_i(clk), .req_o(req), .wr_o(wr), .path_o(path), .sel_o(sel),
        .sub_o(sub), .byte_o(bnum), .wdata_o(wdata), .ack_i(ack), .err_i(err), .rdata_i(rdata));
    // ----------------------------------------
    // expectations
    // ----------------------------------------
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic bad(int c);
        return !(code[c] inside {8'h10, 8'h20, 8'hff});
    endfunction
    function automatic logic [7:0] fault(int c);
        return {4'h0, shorts[c] & sen[c], 2'b00, bad(c)};
    endfunction
    function automatic logic [7:0] diag(int i);
        logic [3:0] g;
        for (int c = 0; c < 4; c++) begin
            g[c] = |fault(c);
        end
        case (i)
            0: return {bad(0) | bad(1) | bad(2) | bad(3), 2'b00, pins[3], |g, pins[2:0]};
            1: return 8'h15;
            3: return {3'h0, pins[5:4], 3'h0};
            4: return 8'h73;
            5: return 8'h08;
            6: return 8'h04;
            7: return {4'h0, g};
            8, 9, 10, 11: return fault(i - 8);
            default: return 8'h00;
        endcase
    endfunction
    function automatic logic [11:0] dac_exp(int c);
        logic [31:0] d;
        d = 32'(val[16*c +: 16]);
        if (d[15] || !(code[c] inside {8'h10, 8'h20})) return 12'h000;
        if (code[c] == 8'h20) return d > 32'd20480 ? 12'ha00 : d[14:3];
        d = d > 32'd32511 ? 32'd32511 : d;
        d = (d * 32'd19418 + 32'd16384) >> 15;
        return d[14:3];
    endfunction
    // ----------------------------------------
    // access and compare
    // ----------------------------------------
    task automatic conclude();
        if (n_fail == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic chk(string what, logic [31:0] e, logic [31:0] g);
        compares++;
        if (g !== e) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic acc(logic w, int p, logic [15:0] s, logic [7:0] sb, logic [4:0] b,
            logic [7:0] wd, output logic [7:0] r, output logic e);
        logic ok;
        host.xfer(w, aopd_path_e'(p), s, sb, b, wd, r, e, ok);
        if (!ok) begin
            n_fail++;
            conclude();
        end
    endtask
    // parameter byte n: 1 short enable, 2..5 channel codes
    task automatic pacc(logic w, int p, int n, logic [7:0] d, output logic [7:0] r);
        logic e;
        case (p)
            0: acc(w, 0, n == 1 ? 16'h0 : 16'(126 + n), 8'h0, n == 1 ? 5'd1 : 5'd0, d, r, e);
            1: acc(w, 1, 16'(16'h3100 + n), 8'h0, 5'd0, d, r, e);
            default: acc(w, 2, 16'h3100, 8'(n + 1), 5'd0, d, r, e);
        endcase
        chk("parameter error flag", 32'h0, 32'(e));
    endtask
    task automatic scan();
        logic [7:0] r;
        logic e;
        logic [7:0] s [20];
        for (int i = 0; i < 20; i++) begin
            acc(0, 0, 16'h0001, 8'h0, 5'(i), 8'h0, s[i], e);
            if (i < 16) chk("diag byte", 32'(diag(i)), 32'(s[i]));
            if (i < 16) dimg[8*i +: 8] = s[i];
            acc(0, 1, 16'h2f01, 8'h0, 5'(i), 8'h0, r, e);
            chk("diag by index", 32'(s[i]), 32'(r));
            acc(0, 2, 16'h5005, i < 16 ? 8'(i + 2) : 8'h13, i < 16 ? 5'd0 : 5'(i - 16),
                8'h0, r, e);
            chk("diag by subindex", 32'(s[i]), 32'(r));
            if (i < 4) begin
                acc(0, 0, 16'h0000, 8'h0, 5'(i), 8'h0, r, e);
                chk("diag head set", 32'(s[i]), 32'(r));
                acc(0, 1, 16'h2f00, 8'h0, 5'(i), 8'h0, r, e);
                chk("diag head index", 32'(s[i]), 32'(r));
            end
        end
        stamp = {s[16], s[17], s[18], s[19]};
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        logic [7:0] r;
        logic [7:0] w;
        logic e;
        logic [31:0] old;
        logic [127:0] prev;
        repeat (12) @(negedge clk);
        rst = 1'b0;
        scan();
        chk("stamp after reset", 32'h0, stamp);
        acc(0, 0, 16'h0000, 8'h0, 5'd4, 8'h0, r, e);
        chk("set 00h byte 4", 32'h100, 32'({e, r}));
        acc(0, 1, 16'h2f00, 8'h0, 5'd4, 8'h0, r, e);
        chk("index 2F00h byte 4", 32'h100, 32'({e, r}));
        acc(0, 2, 16'h5005, 8'h12, 5'd0, 8'h0, r, e);
        chk("subindex 12h", 32'h100, 32'({e, r}));
        for (int k = 0; k < 8; k++) begin
            prev = dimg;
            old = stamp;
            w = 8'(rnd());
            sen = w[3:0];
            pacc(1, k % 3, 1, w, r);
            pacc(0, 1 + k % 2, 1, 8'h0, r);
            chk("short enable", 32'(sen), 32'(r));
            for (int c = 0; c < 4; c++) begin
                code[c] = tbl[(k + c) % 4];
                pacc(1, (k + c) % 3, c + 2, code[c], r);
                pacc(0, 2 - k % 2, c + 2, 8'h0, r);
                chk("function code", 32'(code[c]), 32'(r));
            end
            acc(1, 1, 16'h2f01, 8'h0, 5'(k), 8'hff, r, e);
            chk("diag write flag", 32'h1, 32'(e));
            {pins, shorts} = k == 7 ? 10'h0 : 10'(rnd());
            val = k == 0 ? 64'h5000_4000_7eff_6c00 : k == 1 ? 64'h0000_5001_7fff_ffff
                : {rnd(), rnd()};
            repeat (6) @(negedge clk);
            for (int c = 0; c < 4; c++) begin
                chk("converter code", 32'(dac_exp(c)), 32'(dac[12*c +: 12]));
                chk("channel active", 32'(code[c] inside {8'h10, 8'h20}), 32'(act[c]));
                chk("error indicator", 32'(|fault(c)), 32'(led[c]));
            end
            scan();
            chk("stamp latched", 32'(dimg != prev), 32'(stamp != old));
        end
        conclude();
    end
endmodule

/* src/aopd_bank.sv */
// parameter and diagnostic record bank of a four channel analog output
// assumes fault pins are asynchronous and the access port and output
// data image are driven by logic on SYS_CLK_I
`timescale 1ns/1ps
`include "aopd_cfg.svh"

module aopd_bank #(
    parameter int SLOT = 0
) (
    // clock and reset
    input wire logic SYS_CLK_I,
    input wire logic SYS_RST_I,
    // record access port
    input wire logic ACC_REQ_I,
    input wire logic ACC_WR_I,
    input aopd_pkg::aopd_path_e ACC_PATH_I,
    input wire logic [15:0] ACC_SEL_I,
    input wire logic [7:0] ACC_SUB_I,
    input wire logic [4:0] ACC_BYTE_I,
    input wire logic [7:0] ACC_WDATA_I,
    output logic ACC_ACK_O,
    output logic ACC_ERR_O,
    output logic [7:0] ACC_RDATA_O,
    // fault pins from the output stage
    input wire logic [3:0] CH_SHORT_I,
    input wire logic MOD_FAIL_I,
    input wire logic INT_ERR_I,
    input wire logic EXT_ERR_I,
    input wire logic AUX_MISSING_I,
    input wire logic DIAG_OVF_I,
    input wire logic COMM_ERR_I,
    // output data image
    input wire logic [63:0] CH_VALUE_I,
    // converter and indicators
    output logic [47:0] CH_DAC_O,
    output logic [3:0] CH_ACTIVE_O,
    output logic [3:0] CH_ERR_LED_O
);
    import aopd_pkg::*;

    localparam logic [4:0] US_LAST = 5'(`AOPD_US_CYCLES - 1);
    localparam logic [15:0] SX_PARAM = 16'(`AOPD_SX_PARAM_BASE + SLOT);

    aopd_state_s r_reg;
    aopd_state_s r_next;

    // ------------------------------------------------------------
    // functions
    // ------------------------------------------------------------

    // locate one record byte from the access path
    function automatic aopd_loc_s locate(
        input aopd_path_e path,
        input logic [15:0] sel,
        input logic [7:0] sub,
        input logic [4:0] bnum,
        input logic wr
    );
        aopd_loc_s loc;
        loc = '0;
        case (path)
            AOPD_PATH_RECORD: begin
                if (wr && sel[7:0] == `AOPD_DS_PARAM && sel[15:8] == 8'h00
                        && bnum < 5'd2) begin
                    loc.ok = 1'b1;
                    loc.idx = bnum;
                end else if (wr && sel[15:2] == 14'(`AOPD_DS_FN_BASE >> 2)
                        && bnum == 5'd0) begin
                    loc.ok = 1'b1;
                    loc.idx = 5'(`AOPD_PB_FN0 + sel[1:0]);
                end else if (!wr && sel == 16'(`AOPD_DS_DIAG_FULL)
                        && bnum < `AOPD_DIAG_BYTES) begin
                    loc.ok = 1'b1;
                    loc.diag = 1'b1;
                    loc.idx = bnum;
                end else if (!wr && sel == 16'(`AOPD_DS_DIAG_HEAD)
                        && bnum < `AOPD_DIAG_HEAD_BYTES) begin
                    loc.ok = 1'b1;
                    loc.diag = 1'b1;
                    loc.idx = bnum;
                end
            end
            AOPD_PATH_INDEX: begin
                if (sel >= `AOPD_IX_PARAM_BASE
                        && sel < 16'(`AOPD_IX_PARAM_BASE + `AOPD_PARAM_BYTES)
                        && bnum == 5'd0) begin
                    loc.ok = 1'b1;
                    loc.idx = 5'(sel - `AOPD_IX_PARAM_BASE);
                end else if (!wr && sel == `AOPD_IX_DIAG_FULL
                        && bnum < `AOPD_DIAG_BYTES) begin
                    loc.ok = 1'b1;
                    loc.diag = 1'b1;
                    loc.idx = bnum;
                end else if (!wr && sel == `AOPD_IX_DIAG_HEAD
                        && bnum < `AOPD_DIAG_HEAD_BYTES) begin
                    loc.ok = 1'b1;
                    loc.diag = 1'b1;
                    loc.idx = bnum;
                end
            end
            AOPD_PATH_SUBINDEX: begin
                if (sel == SX_PARAM && sub >= `AOPD_SX_PARAM_FIRST
                        && sub < 8'(`AOPD_SX_PARAM_FIRST + `AOPD_PARAM_BYTES)
                        && bnum == 5'd0) begin
                    loc.ok = 1'b1;
                    loc.idx = 5'(sub - `AOPD_SX_PARAM_FIRST);
                end else if (!wr && sel == `AOPD_SX_DIAG_INDEX
                        && sub >= `AOPD_SX_DIAG_FIRST
                        && sub <= `AOPD_SX_DIAG_LAST && bnum == 5'd0) begin
                    loc.ok = 1'b1;
                    loc.diag = 1'b1;
                    loc.idx = 5'(sub - `AOPD_SX_DIAG_FIRST);
                end else if (!wr && sel == `AOPD_SX_DIAG_INDEX
                        && sub == `AOPD_SX_DIAG_STAMP && bnum < 5'd4) begin
                    loc.ok = 1'b1;
                    loc.diag = 1'b1;
                    loc.idx = 5'(`AOPD_STAMP_BYTE + bnum);
                end
            end
            default: begin
                loc = '0;
            end
        endcase
        return loc;
    endfunction

    // a code the channel can run with
    function automatic logic code_ok(input logic [7:0] code);
        return code == `AOPD_FN_FMT1 || code == `AOPD_FN_FMT2
            || code == `AOPD_FN_OFF;
    endfunction

    // one channel's function code from the packed code register
    function automatic logic [7:0] chan_code(
        input logic [31:0] codes,
        input int c
    );
        return codes[c*8 +: 8];
    endfunction

    // lane of a channel code inside the packed code register
    function automatic int code_lane(
        input logic [4:0] idx
    );
        return 8 * (int'(idx) - int'(`AOPD_PB_FN0));
    endfunction

    // lane of a timestamp byte, most significant byte first
    function automatic int stamp_lane(
        input logic [4:0] idx
    );
        return 8 * (3 - (int'(idx) - int'(`AOPD_STAMP_BYTE)));
    endfunction

    // fault byte of one channel; a short counts only where detection is on
    function automatic logic [7:0] fault_byte(
        input logic bad,
        input logic short_seen,
        input logic short_on
    );
        logic [7:0] f;
        f = 8'h00;
        f[`AOPD_CH_CFG_ERR] = bad;
        f[`AOPD_CH_SHORT] = short_seen && short_on;
        return f;
    endfunction

    // digital value to 12-bit converter code, 10 V at 2048
    function automatic logic [11:0] scale(
        input logic [15:0] d,
        input logic [7:0] code
    );
        logic [15:0] lim;
        logic [31:0] prod;
        logic [15:0] norm;
        lim = 16'h0000;
        prod = 32'h00000000;
        norm = 16'h0000;
        if (d[15]) begin
            norm = 16'h0000;
        end else if (code == `AOPD_FN_FMT1) begin
            lim = (d > `AOPD_FMT1_MAX) ? `AOPD_FMT1_MAX : d;
            prod = 32'(lim) * `AOPD_FMT1_MUL + `AOPD_FMT1_RND;
            norm = prod[30:15];
        end else if (code == `AOPD_FN_FMT2) begin
            norm = (d > `AOPD_FMT2_MAX) ? `AOPD_FMT2_MAX : d;
        end
        return norm[14:3];
    endfunction

    // ------------------------------------------------------------
    // diagnostic image
    // ------------------------------------------------------------

    logic [3:0] short_s;
    logic [3:0] cfg_err;
    logic [7:0] ch_fault [4];
    logic [3:0] grp_err;
    logic [7:0] diag_a;
    logic [7:0] diag_d;
    logic [127:0] diag_img;
    aopd_loc_s loc;
    logic [7:0] rbyte;

    assign short_s = r_reg.sync2[3:0];

    always_comb begin
        for (int c = 0; c < 4; c++) begin
            cfg_err[c] = !code_ok(chan_code(r_reg.fn, c));
            ch_fault[c] = fault_byte(cfg_err[c], short_s[c], r_reg.short_en[c]);
            grp_err[c] = |ch_fault[c];
        end
    end

    always_comb begin
        diag_a = 8'h00;
        diag_a[`AOPD_A_MOD_FAIL] = r_reg.sync2[4];
        diag_a[`AOPD_A_INT_ERR] = r_reg.sync2[5];
        diag_a[`AOPD_A_EXT_ERR] = r_reg.sync2[6];
        diag_a[`AOPD_A_CH_ERR] = |grp_err;
        diag_a[`AOPD_A_AUX_MISS] = r_reg.sync2[7];
        diag_a[`AOPD_A_PARAM_ERR] = |cfg_err;
        diag_d = 8'h00;
        diag_d[`AOPD_D_BUF_OVF] = r_reg.sync2[8];
        diag_d[`AOPD_D_COMM_ERR] = r_reg.sync2[9];
    end

    // bytes 0 to 15, byte 0 in the low lane; unused bytes stay zero
    always_comb begin
        diag_img = '0;
        diag_img[7:0] = diag_a;
        diag_img[15:8] = `AOPD_MODULE_INFO;
        diag_img[31:24] = diag_d;
        diag_img[39:32] = `AOPD_CHANNEL_KIND;
        diag_img[47:40] = `AOPD_DIAG_BITS;
        diag_img[55:48] = `AOPD_CHANNELS;
        diag_img[63:56] = {4'h0, grp_err};
        for (int c = 0; c < 4; c++) begin
            diag_img[64 + c*8 +: 8] = ch_fault[c];
        end
    end

    // ------------------------------------------------------------
    // read data selection
    // ------------------------------------------------------------

    assign loc = locate(ACC_PATH_I, ACC_SEL_I, ACC_SUB_I, ACC_BYTE_I, ACC_WR_I);

    always_comb begin
        rbyte = 8'h00;
        if (loc.diag) begin
            if (loc.idx >= `AOPD_STAMP_BYTE) begin
                // ticker most significant byte first
                rbyte = r_reg.stamp[stamp_lane(loc.idx) +: 8];
            end else begin
                rbyte = diag_img[8*loc.idx[3:0] +: 8];
            end
        end else if (loc.idx == `AOPD_PB_SHORT_EN) begin
            rbyte = {4'h0, r_reg.short_en};
        end else if (loc.idx >= `AOPD_PB_FN0) begin
            rbyte = r_reg.fn[code_lane(loc.idx) +: 8];
        end
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------

    always_comb begin
        r_next = r_reg;
        r_next.sync1 = {COMM_ERR_I, DIAG_OVF_I, AUX_MISSING_I, EXT_ERR_I,
                        INT_ERR_I, MOD_FAIL_I, CH_SHORT_I};
        r_next.sync2 = r_reg.sync1;

        // free running microsecond ticker
        if (r_reg.presc == US_LAST) begin
            r_next.presc = 5'h00;
            r_next.us_cnt = r_reg.us_cnt + 32'h00000001;
        end else begin
            r_next.presc = r_reg.presc + 5'h01;
        end

        // any change of the diagnostic image is an event
        r_next.diag_q = diag_img;
        if (diag_img != r_reg.diag_q) begin
            r_next.stamp = r_reg.us_cnt;
        end

        for (int c = 0; c < 4; c++) begin
            r_next.dac[c*12 +: 12] = cfg_err[c] ? 12'h000
                : scale(CH_VALUE_I[c*16 +: 16], chan_code(r_reg.fn, c));
        end

        case (r_reg.st)
            AOPD_ST_IDLE: begin
                if (ACC_REQ_I) begin
                    r_next.st = AOPD_ST_ANSWER;
                    r_next.err = !loc.ok;
                    r_next.rdata = (loc.ok && !ACC_WR_I) ? rbyte : 8'h00;
                    if (loc.ok && ACC_WR_I) begin
                        if (loc.idx == `AOPD_PB_SHORT_EN) begin
                            r_next.short_en = ACC_WDATA_I[3:0];
                        end else if (loc.idx >= `AOPD_PB_FN0) begin
                            // any code is kept; unsupported ones flag an error
                            r_next.fn[code_lane(loc.idx) +: 8] =
                                ACC_WDATA_I;
                        end
                    end
                end
            end
            AOPD_ST_ANSWER: begin
                r_next.st = AOPD_ST_IDLE;
            end
            default: begin
                r_next.st = AOPD_ST_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------

    always_ff @(posedge SYS_CLK_I) begin
        if (SYS_RST_I) begin
            r_reg <= '0;
            r_reg.st <= AOPD_ST_IDLE;
            r_reg.short_en <= `AOPD_RST_SHORT_EN;
            r_reg.fn <= {4{`AOPD_RST_FN}};
        end else begin
            r_reg <= r_next;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------

    assign ACC_ACK_O = (r_reg.st == AOPD_ST_ANSWER);
    assign ACC_ERR_O = r_reg.err;
    assign ACC_RDATA_O = r_reg.rdata;
    assign CH_DAC_O = r_reg.dac;

    always_comb begin
        for (int c = 0; c < 4; c++) begin
            CH_ACTIVE_O[c] = !cfg_err[c]
                && chan_code(r_reg.fn, c) != `AOPD_FN_OFF;
        end
    end

    // no interrupt output exists; channel errors show on the indicators
    assign CH_ERR_LED_O = grp_err;

endmodule

/* src/aopd_cfg.svh */
// constants of the analog output parameter and diagnostic records
// assumes inclusion by the record bank module only
`ifndef AOPD_CFG_SVH
`define AOPD_CFG_SVH

// parameter record locations
`define AOPD_DS_PARAM 8'h00
`define AOPD_DS_FN_BASE 8'h80
`define AOPD_IX_PARAM_BASE 16'h3100
`define AOPD_SX_PARAM_BASE 16'h3100
`define AOPD_SX_PARAM_FIRST 8'h01
`define AOPD_PARAM_BYTES 5'd6

// diagnostic record locations
`define AOPD_DS_DIAG_FULL 8'h01
`define AOPD_DS_DIAG_HEAD 8'h00
`define AOPD_IX_DIAG_FULL 16'h2f01
`define AOPD_IX_DIAG_HEAD 16'h2f00
`define AOPD_SX_DIAG_INDEX 16'h5005
`define AOPD_SX_DIAG_FIRST 8'h02
`define AOPD_SX_DIAG_LAST 8'h11
`define AOPD_SX_DIAG_STAMP 8'h13
`define AOPD_DIAG_BYTES 5'd20
`define AOPD_DIAG_HEAD_BYTES 5'd4
`define AOPD_STAMP_BYTE 5'd16

// parameter byte positions
`define AOPD_PB_SHORT_EN 5'd1
`define AOPD_PB_FN0 5'd2

// reset values
`define AOPD_RST_SHORT_EN 4'h0
`define AOPD_RST_FN 8'h10

// function codes
`define AOPD_FN_FMT1 8'h10
`define AOPD_FN_FMT2 8'h20
`define AOPD_FN_OFF 8'hff

// scaling limits
`define AOPD_FMT1_MAX 16'h7eff
`define AOPD_FMT2_MAX 16'h5000
`define AOPD_FMT1_MUL 32'h00004bda
`define AOPD_FMT1_RND 32'h00004000

// fixed diagnostic bytes
`define AOPD_MODULE_INFO 8'h15
`define AOPD_CHANNEL_KIND 8'h73
`define AOPD_DIAG_BITS 8'h08
`define AOPD_CHANNELS 8'h04

// diagnostic bit positions
`define AOPD_A_MOD_FAIL 0
`define AOPD_A_INT_ERR 1
`define AOPD_A_EXT_ERR 2
`define AOPD_A_CH_ERR 3
`define AOPD_A_AUX_MISS 4
`define AOPD_A_PARAM_ERR 7
`define AOPD_D_BUF_OVF 3
`define AOPD_D_COMM_ERR 4
`define AOPD_CH_CFG_ERR 0
`define AOPD_CH_SHORT 3

// microsecond ticker timing
`define AOPD_US_NS 1000
`define AOPD_CLK_NS 40
`define AOPD_US_CYCLES (`AOPD_US_NS / `AOPD_CLK_NS)

`endif

/* src/aopd_pkg.sv */
// types of the analog output parameter and diagnostic records
// assumes no other package
package aopd_pkg;

    // access path that addresses a record byte
    typedef enum logic [1:0] {
        AOPD_PATH_RECORD = 2'h0,
        AOPD_PATH_INDEX = 2'h1,
        AOPD_PATH_SUBINDEX = 2'h2
    } aopd_path_e;

    typedef enum logic [1:0] {
        AOPD_ST_IDLE = 2'b01,
        AOPD_ST_ANSWER = 2'b10
    } aopd_state_e;

    // decoded location of one record byte
    typedef struct packed {
        logic ok;
        logic diag;
        logic [4:0] idx;
    } aopd_loc_s;

    typedef struct packed {
        aopd_state_e st;
        logic [7:0] rdata;
        logic err;
        logic [3:0] short_en;
        logic [31:0] fn;
        logic [4:0] presc;
        logic [31:0] us_cnt;
        logic [31:0] stamp;
        logic [9:0] sync1;
        logic [9:0] sync2;
        logic [127:0] diag_q;
        logic [47:0] dac;
    } aopd_state_s;

endpackage
